// >>> hdl/cms_pkg.sv
// Constants, encodings and helper functions of the configuration mode sequencer.
package cms_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned POR_LONG_MS = 100;
  localparam int unsigned POR_SHORT_MS = 12;
  localparam int unsigned POR_LONG_CYCLES = POR_LONG_MS * (CLK_HZ / MS_PER_S);
  localparam int unsigned POR_SHORT_CYCLES = POR_SHORT_MS * (CLK_HZ / MS_PER_S);
  typedef logic [20:0] cms_por_cnt_t;
  localparam logic [3:0] INIT_LAST = 4'h7;
  localparam logic [2:0] SER_BIT_LAST = 3'h7;
  localparam logic [1:0] FPP_EDGE_TAKE = 2'h0;

  // ==========================================================================
  // Load schemes and states
  localparam logic [2:0] SCH_FPP = 3'h0;
  localparam logic [2:0] SCH_AS = 3'h1;
  localparam logic [2:0] SCH_PS = 3'h2;
  localparam logic [2:0] SCH_PPA = 3'h3;
  localparam logic [2:0] SCH_JTAG = 3'h4;
  typedef enum logic [4:0] {
    ST_POR = 5'h01,
    ST_WAIT = 5'h02,
    ST_LOAD = 5'h04,
    ST_INIT = 5'h08,
    ST_USER = 5'h10
  } cms_state_e;

  // ==========================================================================
  // Register map and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LEN = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_STAT = 8'h0c;
  localparam logic [7:0] REG_INT_MASK = 8'h10;
  localparam int CTRL_COMP_BIT = 3;
  localparam int CTRL_RSU_BIT = 4;
  localparam int CTRL_LOCAL_BIT = 5;
  localparam int CTRL_START_BIT = 6;
  localparam logic [5:0] CTRL_RST = 6'h02;
  localparam logic [15:0] LEN_RST = 16'h0100;
  localparam int IRQ_W = 4;
  localparam int IRQ_LOADED = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_USER = 2;
  localparam int IRQ_RECONF = 3;
  localparam int RLE_FLAG_BIT = 7;
  localparam int RLE_RUN_W = 3;

  // ==========================================================================
  // Synchroniser lanes
  localparam int SY_POR = 0;
  localparam int SY_PULL = 1;
  localparam int SY_LVL = 2;
  localparam int SY_CE = 3;
  localparam int SY_RCF = 4;
  localparam int SY_CLK = 5;
  localparam int SY_DATA = 6;
  localparam int SY_W = 14;

  function automatic logic cms_decomp_ok(input logic [2:0] s);
    return (s == SCH_FPP) || (s == SCH_AS) || (s == SCH_PS);
  endfunction

  function automatic logic cms_rsu_ok(input logic [2:0] s);
    return cms_decomp_ok(s) || (s == SCH_PPA);
  endfunction

endpackage

// >>> hdl/cms_load_engine.sv
// Byte assembly and real-time decompression of the incoming bitstream.
`timescale 1ns/1ps
`default_nettype none
module cms_load_engine
  import cms_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic active,
  input wire logic [2:0] scheme,
  input wire logic decomp_en,
  input wire logic clk_rise,
  input wire logic [7:0] data_in,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [7:0] shift_q, shift_d, raw;
  logic [2:0] bit_q, bit_d;
  logic [1:0] edge_q, edge_d;
  logic [RLE_RUN_W-1:0] run_q, run_d;
  logic valid_q, valid_d, got, dec_on;
  logic [7:0] data_q, data_d;

  // ==========================================================================
  // Assembly and expansion
  // (RULE_09) Decompression scope.
  assign dec_on = decomp_en && cms_decomp_ok(scheme);

  always_comb begin
    shift_d = shift_q;
    bit_d = bit_q;
    edge_d = edge_q;
    run_d = run_q;
    valid_d = 1'b0;
    data_d = data_q;
    got = 1'b0;
    raw = data_in;
    if (!active) begin
      shift_d = '0;
      bit_d = '0;
      edge_d = '0;
      run_d = '0;
    end else begin
      if (clk_rise) begin
        if (scheme == SCH_AS || scheme == SCH_PS) begin
          shift_d = {shift_q[6:0], data_in[0]};
          bit_d = bit_q + 3'h1;
          got = (bit_q == SER_BIT_LAST);
          raw = shift_d;
        end else begin
          // (RULE_08) Four clocks per word.
          edge_d = (scheme == SCH_FPP && dec_on) ? edge_q + 2'h1 : FPP_EDGE_TAKE;
          got = (edge_q == FPP_EDGE_TAKE);
        end
      end
      // A run occupies the cycles between clock edges; the host clock must be slow enough.
      if (run_q != '0) begin
        valid_d = 1'b1;
        data_d = 8'h00;
        run_d = run_q - 1'b1;
      end else if (got) begin
        valid_d = 1'b1;
        // (RULE_09) Zero-run expansion.
        if (dec_on && raw[RLE_FLAG_BIT]) begin
          data_d = 8'h00;
          run_d = raw[RLE_RUN_W-1:0];
        end else begin
          data_d = raw;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shift_q <= 8'h00;
      bit_q <= 3'h0;
      edge_q <= 2'h0;
      run_q <= '0;
      valid_q <= 1'b0;
      data_q <= 8'h00;
    end else begin
      shift_q <= shift_d;
      bit_q <= bit_d;
      edge_q <= edge_d;
      run_q <= run_d;
      valid_q <= valid_d;
      data_q <= data_d;
    end
  end

  assign byte_valid = valid_q;
  assign byte_data = data_q;

  chk_decomp_scope: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_09
    (run_q != '0) |-> (dec_on && byte_valid && byte_data == 8'h00))
    else $error("zero run outside a decompressing scheme");

endmodule // cms_load_engine
`default_nettype wire

// >>> hdl/cms_sequencer.sv
// Power-up, load, initialisation and user-mode sequencer with register port.
// Function
// (RULE_01) Power-on delay is 100 ms with delay select low, 12 ms high.
// (RULE_02) User I/O stay high impedance until loading has finished.
// (RULE_03) After loading, initialise: clear registers, enable I/O, enter user mode.
// (RULE_04) Weak pull-ups on during configuration when pull-up select is low.
// (RULE_05) Input level select is captured only at power up.
// (RULE_06) Level select high picks the low-voltage input buffer.
// (RULE_07) Reconfiguration pin in user mode returns to command mode and reloads.
// (RULE_08) Host clocks four times the word rate for parallel decompression.
// (RULE_09) Decompress only in fast parallel, active serial and passive serial.
// (RULE_10) Active serial with remote upgrade allows remote update mode only.
// (RULE_11) User logic starts reconfiguration; errors fall back to a safe image.
// (RULE_12) Remote upgrade in all schemes but boundary-scan loading.
// (RULE_13) Devices chain through chain-enable output to next chain-enable input.
// (RULE_14) Chain-enable output rises only after own load completes.
`timescale 1ns/1ps
`default_nettype none
module cms_sequencer
  import cms_pkg::*;
#(
  parameter cms_por_cnt_t POR_LONG_CYC = cms_por_cnt_t'(POR_LONG_CYCLES),
  parameter cms_por_cnt_t POR_SHORT_CYC = cms_por_cnt_t'(POR_SHORT_CYCLES)
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic por_delay_select,
  input wire logic weak_pullup_select,
  input wire logic config_input_level_select,
  input wire logic chain_enable_in,
  input wire logic reconfig_req_n,
  input wire logic config_clock,
  input wire logic [7:0] config_data,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic user_io_enable,
  output logic weak_pullup_enable,
  output logic low_volt_buf_sel,
  output logic user_mode,
  output logic init_clear,
  output logic chain_enable_out,
  output logic safe_image_sel,
  output logic cell_wr_valid,
  output logic [7:0] cell_wr_data
);

  // ==========================================================================
  // Pin synchronisers
  logic [SY_W-1:0] sync1_q, sync2_q;
  logic clk_prev_q, clk_rise;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      clk_prev_q <= 1'b0;
    end else begin
      sync1_q <= {config_data, config_clock, reconfig_req_n, chain_enable_in,
                  config_input_level_select, weak_pullup_select, por_delay_select};
      sync2_q <= sync1_q;
      clk_prev_q <= sync2_q[SY_CLK];
    end
  end
  assign clk_rise = sync2_q[SY_CLK] && !clk_prev_q;

  // ==========================================================================
  // Register port
  logic [5:0] ctrl_q, ctrl_d;
  logic [15:0] len_q, len_d;
  logic [IRQ_W-1:0] int_stat_q, int_stat_d, int_mask_q, int_mask_d, ev;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic [2:0] scheme;
  logic rsu_act, local_eff, sw_start, decomp_act;
  cms_state_e state_q, state_d;
  logic lvl_q, lvl_d, safe_q, safe_d, err_q, err_d;

  assign scheme = ctrl_q[2:0];
  // (RULE_12) Remote upgrade scope.
  assign rsu_act = ctrl_q[CTRL_RSU_BIT] && cms_rsu_ok(scheme);
  // (RULE_10) No local update under active serial.
  assign local_eff = ctrl_q[CTRL_LOCAL_BIT] && rsu_act && (scheme != SCH_AS);
  assign decomp_act = ctrl_q[CTRL_COMP_BIT] && cms_decomp_ok(scheme);
  assign sw_start = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_START_BIT];

  always_comb begin
    ctrl_d = ctrl_q;
    len_d = len_q;
    int_mask_d = int_mask_q;
    int_stat_d = int_stat_q;
    rdata_d = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: ctrl_d = reg_wdata[5:0];
        REG_LEN: len_d = reg_wdata[15:0];
        REG_INT_STAT: int_stat_d = int_stat_q & ~reg_wdata[IRQ_W-1:0];
        REG_INT_MASK: int_mask_d = reg_wdata[IRQ_W-1:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
    // New events win over a clear in the same cycle.
    int_stat_d = int_stat_d | ev;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: rdata_d = {26'h0, ctrl_q};
        REG_LEN: rdata_d = {16'h0, len_q};
        REG_STATUS: rdata_d = {21'h0, decomp_act, local_eff, rsu_act, err_q, safe_q,
                               lvl_q, state_q};
        REG_INT_STAT: rdata_d = {28'h0, int_stat_q};
        REG_INT_MASK: rdata_d = {28'h0, int_mask_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    irq_d = |(int_stat_d & int_mask_d);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RST;
      len_q <= LEN_RST;
      int_stat_q <= '0;
      int_mask_q <= '0;
      rdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      len_q <= len_d;
      int_stat_q <= int_stat_d;
      int_mask_q <= int_mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end
  assign reg_rdata = rdata_q;
  assign irq = irq_q;

  // ==========================================================================
  // Load engine
  logic byte_valid;
  logic [7:0] byte_data;

  cms_load_engine u_engine (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .active(state_q == ST_LOAD),
    .scheme(scheme),
    .decomp_en(ctrl_q[CTRL_COMP_BIT]),
    .clk_rise(clk_rise),
    .data_in(sync2_q[SY_W-1:SY_DATA]),
    .byte_valid(byte_valid),
    .byte_data(byte_data)
  );

  // ==========================================================================
  // Mode sequencer
  cms_por_cnt_t por_cnt_q, por_cnt_d, por_limit;
  logic [3:0] init_cnt_q, init_cnt_d;
  logic [15:0] byte_cnt_q, byte_cnt_d;
  logic [7:0] sum_q, sum_d, cell_data_q, cell_data_d;
  logic io_q, io_d, pull_q, pull_d, ceo_q, ceo_d, clr_q, clr_d, cell_q, cell_d, cmd_mode;

  // (RULE_01) Delay choice.
  assign por_limit = sync2_q[SY_POR] ? POR_SHORT_CYC - 1'b1 : POR_LONG_CYC - 1'b1;
  assign cmd_mode = (state_q == ST_POR) || (state_q == ST_WAIT) || (state_q == ST_LOAD);

  always_comb begin
    state_d = state_q;
    por_cnt_d = por_cnt_q;
    init_cnt_d = init_cnt_q;
    byte_cnt_d = byte_cnt_q;
    sum_d = sum_q;
    lvl_d = lvl_q;
    safe_d = safe_q;
    err_d = err_q;
    io_d = io_q;
    ceo_d = ceo_q;
    clr_d = 1'b0;
    cell_d = 1'b0;
    cell_data_d = cell_data_q;
    ev = '0;
    // (RULE_04) Pull-ups only in command mode.
    pull_d = cmd_mode && !sync2_q[SY_PULL];
    case (state_q)
      ST_POR: begin
        por_cnt_d = por_cnt_q + 1'b1;
        if (por_cnt_q >= por_limit) begin
          // (RULE_05) Level captured once.
          lvl_d = sync2_q[SY_LVL];
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        byte_cnt_d = '0;
        sum_d = 8'h00;
        // (RULE_13) Load starts on chain enable.
        if (sync2_q[SY_CE] && sync2_q[SY_RCF]) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (byte_valid) begin
          if (byte_cnt_q < len_q) begin
            cell_d = 1'b1;
            cell_data_d = byte_data;
            sum_d = sum_q ^ byte_data;
            byte_cnt_d = byte_cnt_q + 1'b1;
          end else if (byte_data == sum_q) begin
            // (RULE_14) Pass the chain on.
            ceo_d = 1'b1;
            ev[IRQ_LOADED] = 1'b1;
            err_d = 1'b0;
            init_cnt_d = '0;
            state_d = ST_INIT;
          end else begin
            // (RULE_11) Error fallback.
            ev[IRQ_ERROR] = 1'b1;
            err_d = 1'b1;
            safe_d = safe_q || rsu_act;
            state_d = ST_WAIT;
          end
        end
      end
      ST_INIT: begin
        // (RULE_03) Clear and enable I/O.
        clr_d = 1'b1;
        io_d = 1'b1;
        init_cnt_d = init_cnt_q + 1'b1;
        if (init_cnt_q == INIT_LAST) begin
          clr_d = 1'b0;
          ev[IRQ_USER] = 1'b1;
          state_d = ST_USER;
        end
      end
      ST_USER: begin
        // (RULE_07) Pin or (RULE_11) software reconfiguration.
        if (!sync2_q[SY_RCF] || (sw_start && rsu_act)) begin
          io_d = 1'b0;
          ceo_d = 1'b0;
          ev[IRQ_RECONF] = 1'b1;
          // (RULE_10) Remote update selects the new image.
          if (!local_eff) begin
            safe_d = 1'b0;
          end
          state_d = ST_WAIT;
        end
      end
      default: state_d = ST_POR;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= ST_POR;
      por_cnt_q <= '0;
      init_cnt_q <= 4'h0;
      byte_cnt_q <= 16'h0000;
      sum_q <= 8'h00;
      lvl_q <= 1'b0;
      safe_q <= 1'b0;
      err_q <= 1'b0;
      io_q <= 1'b0;
      pull_q <= 1'b0;
      ceo_q <= 1'b0;
      clr_q <= 1'b0;
      cell_q <= 1'b0;
      cell_data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      por_cnt_q <= por_cnt_d;
      init_cnt_q <= init_cnt_d;
      byte_cnt_q <= byte_cnt_d;
      sum_q <= sum_d;
      lvl_q <= lvl_d;
      safe_q <= safe_d;
      err_q <= err_d;
      io_q <= io_d;
      pull_q <= pull_d;
      ceo_q <= ceo_d;
      clr_q <= clr_d;
      cell_q <= cell_d;
      cell_data_q <= cell_data_d;
    end
  end

  // (RULE_02) Output enable only after loading.
  assign user_io_enable = io_q;
  assign weak_pullup_enable = pull_q;
  // (RULE_06) Buffer choice from captured level.
  assign low_volt_buf_sel = lvl_q;
  assign user_mode = (state_q == ST_USER);
  assign init_clear = clr_q;
  assign chain_enable_out = ceo_q;
  assign safe_image_sel = safe_q;
  assign cell_wr_valid = cell_q;
  assign cell_wr_data = cell_data_q;

  // ==========================================================================
  // Checks
  sequence s_init_run;
    (state_q == ST_INIT) [*8];
  endsequence

  chk_io_hiz: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_02
    user_io_enable |-> (state_q == ST_INIT || state_q == ST_USER))
    else $error("user I/O enabled before loading finished");
  chk_por_delay: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_01
    (state_q == ST_WAIT && $past(state_q) == ST_POR) |-> $past(por_cnt_q) >= $past(por_limit))
    else $error("power-on delay ended early");
  chk_lvl_hold: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_05
    (state_q != ST_POR) |=> $stable(low_volt_buf_sel))
    else $error("level select changed after power up");
  chk_init_user: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_03
    (state_q == ST_INIT && $past(state_q) == ST_LOAD) |-> s_init_run ##1 (user_mode && io_q))
    else $error("initialisation did not reach user mode in eight cycles");
  chk_pullup: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_04
    ($past(cmd_mode) && !$past(sys_rst)) |-> (weak_pullup_enable == !$past(sync2_q[SY_PULL])))
    else $error("weak pull-up does not follow its select");
  chk_reconf_pin: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_07
    (user_mode && !sync2_q[SY_RCF]) |=> (state_q == ST_WAIT && !user_io_enable))
    else $error("reconfiguration pin ignored in user mode");
  chk_ceo_after: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_14
    $rose(chain_enable_out) |-> ($past(state_q) == ST_LOAD && state_q == ST_INIT))
    else $error("chain enable out before load complete");
  chk_safe_fall: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_11
    (ev[IRQ_ERROR] && rsu_act) |=> (safe_image_sel && state_q == ST_WAIT) ##1 int_stat_q[IRQ_ERROR])
    else $error("load error did not fall back to the safe image");
  chk_rsu_jtag: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_12
    (ev[IRQ_ERROR] && scheme == SCH_JTAG) |=> $stable(safe_image_sel))
    else $error("remote upgrade acted in boundary-scan loading");
  chk_as_remote: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_10
    (user_mode && sw_start && rsu_act && scheme == SCH_AS) |=> !safe_image_sel)
    else $error("local update mode used under active serial");

endmodule // cms_sequencer
`default_nettype wire

// >>> bench/cms_cfg_mem.sv
// Behavioural configuration memory that clocks image bytes into the sequencer.
`timescale 1ns/1ps
`default_nettype none
module cms_cfg_mem (
  output var logic config_clock,
  output var logic [7:0] config_data
);
  // ==========================================================================
  // Link clock and data
  // The clock stands still between frames, as a real memory only clocks on demand.
  initial begin
    config_clock = 1'b0;
    config_data = 8'h00;
  end

  // one, four or eight clocks per word
  // Serial bytes take eight edges, MSB first on bit 0. A compressed fast parallel word
  // is held over four edges. After the frame the line flips, so stale data never looks valid.
  task automatic send(input logic [7:0] b, input int edges);
    for (int i = 0; i < edges; i++) begin
      config_data = (edges == 8) ? {7'h00, b[7 - i]} : b;
      #200;
      config_clock = 1'b1;
      #200;
      config_clock = 1'b0;
    end
    config_data = ~config_data;
  endtask
endmodule // cms_cfg_mem
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking testbench of the configuration mode sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cms_pkg::*;
  logic core_clk, sys_rst, por_delay_select, weak_pullup_select, config_input_level_select;
  logic chain_enable_in, reconfig_req_n, reg_wr, reg_rd, irq, user_io_enable;
  logic weak_pullup_enable, low_volt_buf_sel, user_mode, init_clear, chain_enable_out;
  logic safe_image_sel, cell_wr_valid, config_clock, rd_pend;
  logic [7:0] config_data, reg_addr, cell_wr_data;
  logic [31:0] reg_wdata, reg_rdata, e;
  logic [7:0] exp_q[$];
  logic [31:0] rexp_q[$], rmsk_q[$];
  int n_errors, check_count, cycles, n_clear;
  int seed = 32'h156ee5dd;

  // ==========================================================================
  // Clock, design and partner
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Short power-on counts keep the run brief; expectations use the same figures.
  cms_sequencer #(.POR_LONG_CYC(21'd40), .POR_SHORT_CYC(21'd20)) u_cms_sequencer (
    .core_clk, .sys_rst, .por_delay_select, .weak_pullup_select, .config_input_level_select,
    .chain_enable_in, .reconfig_req_n, .config_clock, .config_data, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq, .user_io_enable, .weak_pullup_enable,
    .low_volt_buf_sel, .user_mode, .init_clear, .chain_enable_out, .safe_image_sel,
    .cell_wr_valid, .cell_wr_data
  );

  cms_cfg_mem u_cms_cfg_mem (.config_clock, .config_data);

  // ==========================================================================
  // Checking
  task automatic err(input string m);
    n_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) err($sformatf("cell byte %h, wanted %h", got, exp));
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    check_count++;
    if ((got & m) !== (exp & m)) err($sformatf("read %h, wanted %h", got, exp));
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) err($sformatf("level %b, wanted %b", got, exp));
  endtask

  task automatic final_report();
    $display("errors %0d, checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    rd_pend <= reg_rd;
    if (init_clear === 1'b1) n_clear <= n_clear + 1;
    if (cell_wr_valid === 1'b1) begin
      if (exp_q.size() == 0) err("stray cell byte");
      else cmp_byte(cell_wr_data, exp_q.pop_front());
    end
    if (rd_pend === 1'b1) cmp_reg(reg_rdata, rexp_q.pop_front(), rmsk_q.pop_front());
    if (cycles == 30000) begin
      err("timeout");
      final_report();
    end
  end

  // ==========================================================================
  // Drivers
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    rexp_q.push_back(x);
    rmsk_q.push_back(m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    tick(1);
  endtask

  task automatic do_reset(input logic sel, input int lim);
    sys_rst <= 1'b1;
    por_delay_select <= sel;
    chain_enable_in <= 1'b0;
    tick(3);
    sys_rst <= 1'b0;
    tick(lim - 6);
    rd(REG_STATUS, 32'h1, 32'h1f);
    tick(10);
    rd(REG_STATUS, 32'h2, 32'h1f);
  endtask

  task automatic load(input logic [2:0] s, input logic comp, rsu, bad, input int n);
    logic [7:0] img[$];
    logic [7:0] b, sum;
    logic run;
    int edges;
    sum = 8'h00;
    n_clear <= 0;
    edges = (s == SCH_AS || s == SCH_PS) ? 8 : ((comp && s == SCH_FPP) ? 4 : 1);
    chain_enable_in <= 1'b0;
    reconfig_req_n <= 1'b0;
    tick(4);
    reconfig_req_n <= 1'b1;
    for (int i = 0; i < n; i++) begin
      b = (comp && i == 1) ? 8'h82 : 8'($random(seed)) & (comp ? 8'h7f : 8'hff);
      img.push_back(b);
      run = comp && s < SCH_PPA && b[7];
      for (int k = 0; k <= (run ? int'(b[2:0]) : 0); k++) begin
        exp_q.push_back(run ? 8'h00 : b);
        sum ^= exp_q[$];
      end
    end
    wr(REG_CTRL, 32'({rsu, comp, s}));
    wr(REG_LEN, 32'(exp_q.size()));
    chain_enable_in <= 1'b1;
    tick(4);
    cmp_bit(chain_enable_out, 1'b0);
    cmp_bit(user_io_enable, 1'b0);
    foreach (img[i]) u_cms_cfg_mem.send(img[i], edges);
    cmp_bit(chain_enable_out, 1'b0);
    u_cms_cfg_mem.send(sum ^ {7'h00, bad}, edges);
    tick(60);
    cmp_bit(user_mode, !bad);
    cmp_bit(user_io_enable, !bad);
    cmp_bit(chain_enable_out, !bad);
    cmp_bit(n_clear == (bad ? 0 : 7), 1'b1);
    cmp_bit(exp_q.size() == 0, 1'b1);
    if (bad) cmp_bit(safe_image_sel, rsu && s != SCH_JTAG);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {sys_rst, por_delay_select, config_input_level_select, reconfig_req_n} = 4'hf;
    {weak_pullup_select, chain_enable_in, reg_wr, reg_rd, rd_pend} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    tick(1);
    do_reset(1'b1, 20);
    cmp_bit(low_volt_buf_sel, 1'b1);
    cmp_bit(weak_pullup_enable, 1'b1);
    cmp_bit(user_io_enable, 1'b0);
    rd(REG_CTRL, 32'h2, 32'h3f);
    rd(REG_LEN, 32'h100, 32'hffff);
    rd(REG_INT_MASK, 32'h0, 32'hf);
    wr(8'h14, 32'hffffffff);
    rd(8'h14, 32'h0, 32'hffffffff);
    config_input_level_select <= 1'b0;
    weak_pullup_select <= 1'b1;
    u_cms_cfg_mem.send(8'h5a, 1);
    tick(1);
    cmp_bit(low_volt_buf_sel, 1'b1);
    cmp_bit(weak_pullup_enable, 1'b0);
    for (int s = 0; s < 5; s++) begin
      e = 32'h0;
      e[8] = (s != 4);
      e[9] = (s == 0 || s == 2 || s == 3);
      e[10] = (s < 3);
      wr(REG_CTRL, 32'h38 | 32'(s));
      rd(REG_STATUS, e, 32'h700);
    end
    load(SCH_PS, 1'b0, 1'b0, 1'b0, 6);
    cmp_bit(irq, 1'b0);
    rd(REG_INT_STAT, 32'h5, 32'h5);
    wr(REG_INT_MASK, 32'h4);
    cmp_bit(irq, 1'b1);
    wr(REG_INT_STAT, 32'hf);
    cmp_bit(irq, 1'b0);
    rd(REG_STATUS, 32'h10, 32'h1f);
    for (int s = 0; s < 5; s++) load(3'(s), 1'b0, 1'b0, 1'b0, 4);
    for (int s = 0; s < 5; s++) load(3'(s), 1'b1, 1'b0, 1'b0, 5);
    load(SCH_JTAG, 1'b0, 1'b1, 1'b1, 4);
    load(SCH_AS, 1'b0, 1'b1, 1'b1, 4);
    rd(REG_INT_STAT, 32'h2, 32'h2);
    load(SCH_AS, 1'b0, 1'b1, 1'b0, 4);
    cmp_bit(safe_image_sel, 1'b1);
    wr(REG_CTRL, 32'h51);
    tick(10);
    cmp_bit(user_mode, 1'b0);
    cmp_bit(safe_image_sel, 1'b0);
    do_reset(1'b0, 40);
    cmp_bit(low_volt_buf_sel, 1'b0);
    final_report();
  end
endmodule // testbench
`default_nettype wire
